// File: pkg/cfec_pkg.sv
// Constants and types for the converter fault and enable control block
package cfec_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CLK_NS = 10;
   localparam int RAMP_US = 1000;
   localparam int RAMP_CYC_DEF = RAMP_US * 1000 / CLK_NS;
   localparam int RESTART_RAMPS = 7;
   localparam int RESTART_CYC_DEF = RESTART_RAMPS * RAMP_CYC_DEF;
   localparam int TOFF_DLY_US = 100;
   localparam int RAMP_DOWN_TIME_US = 1000;
   localparam int TOFF_CYC_DEF = (TOFF_DLY_US + RAMP_DOWN_TIME_US) * 1000 / CLK_NS;
   localparam int SW_PERIOD_NS = 2000;
   localparam logic [7:0] SW_PERIOD_CYC = 8'(SW_PERIOD_NS / CLK_NS);
   localparam logic [7:0] SS_CYCLES = 8'h80;
   // Cooling hysteresis is judged by the external comparator
   localparam int OT_HYST_C = 20;

   // ==========================================================
   // On/off command register and command codes
   localparam logic [7:0] OPER_ADDR = 8'h01;
   localparam logic [7:0] CLRF_ADDR = 8'h03;
   localparam logic [7:0] OPER_RST = 8'h00;
   localparam logic [7:0] OPER_RW_MASK = 8'hFC;
   localparam int ON_BIT = 7;
   localparam int SOFT_BIT = 6;
   localparam int MRG_MSB = 5;
   localparam int MRG_LSB = 2;
   localparam logic [3:0] MRG_NOM_IGN = 4'h1;
   localparam logic [3:0] MRG_LOW_IGN = 4'h5;
   localparam logic [3:0] MRG_LOW_ACT = 4'h6;
   localparam logic [3:0] MRG_HI_IGN = 4'h9;
   localparam logic [3:0] MRG_HI_ACT = 4'hA;
   localparam logic [1:0] MSEL_NOM = 2'h0;
   localparam logic [1:0] MSEL_LOW = 2'h1;
   localparam logic [1:0] MSEL_HIGH = 2'h2;

   // ==========================================================
   // Status bits and synchroniser lanes
   localparam int ST_OVW = 0;
   localparam int ST_UVW = 1;
   localparam int ST_UVF = 2;
   localparam int ST_TON = 3;
   localparam int ST_OT = 4;
   localparam int ST_VIN = 5;
   localparam int ST_W = 6;
   localparam int IX_EN = 0;
   localparam int IX_OVW = 1;
   localparam int IX_UVW = 2;
   localparam int IX_UVF = 3;
   localparam int IX_TON = 4;
   localparam int IX_OT = 5;
   localparam int IX_OTCOOL = 6;
   localparam int IX_BG = 7;
   localparam int IX_VIN = 8;
   localparam int IX_REQ = 9;
   localparam int IX_W = 10;

   typedef enum logic [1:0] {
      CFEC_RSP_IGN = 2'h0,
      CFEC_RSP_LATCH = 2'h1,
      CFEC_RSP_RESTART = 2'h2
   } cfec_rsp_t;

   typedef enum logic [2:0] {
      CFEC_OFF = 3'h0,
      CFEC_RAMP = 3'h1,
      CFEC_RUN = 3'h3,
      CFEC_SOFTOFF = 3'h2,
      CFEC_HOLD = 3'h6,
      CFEC_LATCH = 3'h7,
      CFEC_COOL = 3'h5
   } cfec_state_t;
endpackage : cfec_pkg

// File: logic/cfec_sync.sv
// Three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module cfec_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r, s2_r, s3_r, q_nxt;

   // ==========================================================
   // Agreement filter per lane
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_lane
         always_comb begin
            q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q[i];
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q <= q_nxt;
      end
   end
endmodule : cfec_sync
`default_nettype wire

// File: logic/cfec_ctrl.sv
// Converter fault response, start-up ramp and enable control
//
// Function
// RULE1 - Overtemperature restart: FETs off until temperature fell 20C below trip
// RULE2 - Bandgap overtemperature always shuts FETs off, restarts after cooling
// RULE3 - OV/UV warnings keep PWM, drop power good, alert; OV checked in ramp
// RULE4 - UV fault: latch off or retry after 7 ramps; ignored during ramp
// RULE5 - Ramp timeout: latch, retry after 7 ramps, or ignore; alert, power good low
// RULE6 - Fixed-frequency continuous conduction, no pulse skipping
// RULE7 - Low-side on-time grows over the first 128 switching cycles
// RULE8 - After 128 cycles low side fully complementary to high side
// RULE9 - Enable pin polarity selectable; default pin only, active high
// RULE10 - Command-only mode ignores the enable pin
// RULE11 - Combined mode needs both pin asserted and on bit set
// RULE12 - Operating mode persists until new command or pin change
// RULE13 - Loop slave refuses on/off command: ignore, NACK, invalid command, alert
// RULE14 - On bit clear disables switching, both drivers low
// RULE15 - On bit set starts only with input ok, command gating, no fault
// RULE16 - Soft-off bit picks delayed ramp-down or immediate off
// RULE17 - Writes to read-only bits are discarded
// RULE18 - On and soft-off both set is invalid data: flags and alert
// RULE19 - Latched off until re-enabled by pin or command
// RULE20 - Margin field decodes nominal, low, high; other codes invalid data
// RULE21 - Power-up, command-response and pin-response bits decide start-up
// RULE22 - Pin-action bit picks immediate or delayed off from the pin
`timescale 1ns/10ps
`default_nettype none
module cfec_ctrl #(
   parameter int RAMP_CYC = cfec_pkg::RAMP_CYC_DEF,
   parameter int RESTART_CYC = cfec_pkg::RESTART_CYC_DEF,
   parameter int TOFF_CYC = cfec_pkg::TOFF_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic lk_req,
   input wire logic lk_write,
   input wire logic [7:0] lk_code,
   input wire logic [7:0] lk_wdata,
   output logic lk_busy,
   output logic lk_done,
   output logic lk_nack,
   output logic [7:0] lk_rdata,
   input wire logic en_pin,
   input wire logic ov_warn_in,
   input wire logic uv_warn_in,
   input wire logic uv_fault_in,
   input wire logic ton_max_in,
   input wire logic ot_fault_in,
   input wire logic ot_cool_in,
   input wire logic bg_ot_in,
   input wire logic vin_ok_in,
   input wire logic cfg_power_up,
   input wire logic cfg_cmd_resp,
   input wire logic cfg_pin_resp,
   input wire logic cfg_pin_pol,
   input wire logic cfg_pin_action,
   input wire logic loop_slave,
   input wire logic [1:0] uv_resp,
   input wire logic [1:0] ton_resp,
   input wire logic [1:0] ot_resp,
   input wire logic [5:0] alert_mask,
   input wire logic [7:0] pwm_duty,
   output logic hs_gate,
   output logic ls_gate,
   output logic power_good,
   output logic alert,
   output logic [1:0] margin_sel,
   output logic [5:0] flt_status,
   output logic cml_flag,
   output logic ivd_flag,
   output logic ivc_flag
);
   import cfec_pkg::*;

   function automatic logic kills(input logic [1:0] rsp);
      kills = (rsp != CFEC_RSP_IGN);
   endfunction : kills

   function automatic logic restarts(input logic [1:0] rsp);
      restarts = (rsp == CFEC_RSP_RESTART);
   endfunction : restarts

   // ==========================================================
   // Link domain: request capture and answer return
   logic lrst_m, lrst_q, lk_tgl_r, lk_tgl_nxt, lk_wr_r, lk_wr_nxt;
   logic [7:0] lk_code_r, lk_code_nxt, lk_wdata_r, lk_wdata_nxt;
   logic ans_seen_r, ans_seen_nxt, ans_tgl_l, busy_nxt, done_nxt, nack_nxt;
   logic [7:0] rdata_nxt;
   logic ans_tgl_r, ans_nack_r;
   logic [7:0] ans_rdata_r;

   // Level reset carried into the link domain
   always_ff @(posedge link_clk) begin
      lrst_m <= rst;
      lrst_q <= lrst_m;
   end

   cfec_sync #(.W(1)) u_ans_sync (
      .clk(link_clk),
      .rst(lrst_q),
      .d(ans_tgl_r),
      .q(ans_tgl_l)
   );

   // Request bundle stays frozen while busy, so the clk side may read it
   always_comb begin
      lk_tgl_nxt = lk_tgl_r;
      lk_wr_nxt = lk_wr_r;
      lk_code_nxt = lk_code_r;
      lk_wdata_nxt = lk_wdata_r;
      ans_seen_nxt = ans_seen_r;
      busy_nxt = lk_busy;
      done_nxt = 1'b0;
      nack_nxt = lk_nack;
      rdata_nxt = lk_rdata;
      if (!lk_busy && lk_req) begin
         lk_tgl_nxt = !lk_tgl_r;
         lk_wr_nxt = lk_write;
         lk_code_nxt = lk_code;
         lk_wdata_nxt = lk_wdata;
         busy_nxt = 1'b1;
      end else if (lk_busy && (ans_tgl_l != ans_seen_r)) begin
         ans_seen_nxt = ans_tgl_l;
         busy_nxt = 1'b0;
         done_nxt = 1'b1;
         nack_nxt = ans_nack_r;
         rdata_nxt = ans_rdata_r;
      end
   end

   always_ff @(posedge link_clk) begin
      if (lrst_q) begin
         lk_tgl_r <= 1'b0;
         lk_wr_r <= 1'b0;
         lk_code_r <= 8'h00;
         lk_wdata_r <= 8'h00;
         ans_seen_r <= 1'b0;
         lk_busy <= 1'b0;
         lk_done <= 1'b0;
         lk_nack <= 1'b0;
         lk_rdata <= 8'h00;
      end else begin
         lk_tgl_r <= lk_tgl_nxt;
         lk_wr_r <= lk_wr_nxt;
         lk_code_r <= lk_code_nxt;
         lk_wdata_r <= lk_wdata_nxt;
         ans_seen_r <= ans_seen_nxt;
         lk_busy <= busy_nxt;
         lk_done <= done_nxt;
         lk_nack <= nack_nxt;
         lk_rdata <= rdata_nxt;
      end
   end

   // ==========================================================
   // Pin synchronisers
   logic [IX_W-1:0] pin_q;

   cfec_sync #(.W(IX_W)) u_pin_sync (
      .clk(clk),
      .rst(rst),
      .d({lk_tgl_r, vin_ok_in, bg_ot_in, ot_cool_in, ot_fault_in,
          ton_max_in, uv_fault_in, uv_warn_in, ov_warn_in, en_pin}),
      .q(pin_q)
   );

   // ==========================================================
   // Command decode and status
   logic req_seen_r, req_seen_nxt, req_evt, ans_tgl_nxt, ans_nack_nxt;
   logic [7:0] ans_rdata_nxt, op_r, op_nxt;
   logic strap_r, strap_nxt, pol_r, pol_nxt, slave_r, slave_nxt;
   logic ivd_set, ivc_set, clr, cml_nxt, ivd_nxt, ivc_nxt, alert_nxt;
   logic mrg_ok;
   logic [3:0] wmrg;
   logic [5:0] stat_set, stat_nxt;
   cfec_state_t st_r, st_nxt;
   logic active, in_ramp;

   assign req_evt = pin_q[IX_REQ] != req_seen_r;
   assign wmrg = lk_wdata_r[MRG_MSB:MRG_LSB];
   assign mrg_ok = !(wmrg[3] && wmrg[2]) && (wmrg != 4'h4) && (wmrg != 4'h7)
      && (wmrg != 4'h8) && (wmrg != 4'hB); // [RULE20]

   always_comb begin
      req_seen_nxt = req_seen_r;
      ans_tgl_nxt = ans_tgl_r;
      ans_nack_nxt = ans_nack_r;
      ans_rdata_nxt = ans_rdata_r;
      op_nxt = op_r;
      ivd_set = 1'b0;
      ivc_set = 1'b0;
      clr = 1'b0;
      // Straps caught once, in the first cycle after reset release
      strap_nxt = 1'b1;
      pol_nxt = strap_r ? pol_r : cfg_pin_pol; // [RULE9]
      slave_nxt = strap_r ? slave_r : loop_slave;
      if (req_evt) begin
         req_seen_nxt = pin_q[IX_REQ];
         ans_tgl_nxt = !ans_tgl_r;
         ans_nack_nxt = 1'b0;
         ans_rdata_nxt = 8'h00;
         if (lk_code_r == OPER_ADDR) begin
            if (slave_r) begin
               ans_nack_nxt = 1'b1; // [RULE13]
               ivc_set = 1'b1;
            end else if (!lk_wr_r) begin
               ans_rdata_nxt = op_r;
            end else if ((lk_wdata_r[ON_BIT] && lk_wdata_r[SOFT_BIT]) || !mrg_ok) begin
               ivd_set = 1'b1; // [RULE18]
            end else begin
               op_nxt = lk_wdata_r & OPER_RW_MASK; // [RULE17] [RULE12]
            end
         end else if (lk_code_r == CLRF_ADDR && lk_wr_r) begin
            clr = 1'b1;
         end else begin
            ans_nack_nxt = 1'b1;
            ivc_set = 1'b1;
         end
      end
      // A new event in the clearing cycle survives the clear
      stat_nxt = (clr ? 6'h00 : flt_status) | stat_set;
      ivd_nxt = (clr ? 1'b0 : ivd_flag) | ivd_set;
      ivc_nxt = (clr ? 1'b0 : ivc_flag) | ivc_set;
      cml_nxt = (clr ? 1'b0 : cml_flag) | ivd_set | ivc_set; // [RULE18]
      alert_nxt = |(stat_nxt & ~alert_mask) | cml_nxt; // [RULE3] [RULE13]
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         req_seen_r <= 1'b0;
         ans_tgl_r <= 1'b0;
         ans_nack_r <= 1'b0;
         ans_rdata_r <= 8'h00;
         op_r <= OPER_RST;
         strap_r <= 1'b0;
         pol_r <= 1'b1;
         slave_r <= 1'b0;
         flt_status <= 6'h00;
         ivd_flag <= 1'b0;
         ivc_flag <= 1'b0;
         cml_flag <= 1'b0;
         alert <= 1'b0;
      end else begin
         req_seen_r <= req_seen_nxt;
         ans_tgl_r <= ans_tgl_nxt;
         ans_nack_r <= ans_nack_nxt;
         ans_rdata_r <= ans_rdata_nxt;
         op_r <= op_nxt;
         strap_r <= strap_nxt;
         pol_r <= pol_nxt;
         slave_r <= slave_nxt;
         flt_status <= stat_nxt;
         ivd_flag <= ivd_nxt;
         ivc_flag <= ivc_nxt;
         cml_flag <= cml_nxt;
         alert <= alert_nxt;
      end
   end

   // ==========================================================
   // Enable decision and fault qualification
   logic pin_act, run_req, off_fast, mrg_ign, ot_kill, uvf_evt, ton_evt;
   logic [1:0] uv_eff;

   assign active = (st_r == CFEC_RAMP) || (st_r == CFEC_RUN) || (st_r == CFEC_SOFTOFF);
   assign in_ramp = (st_r == CFEC_RAMP);
   assign pin_act = (pin_q[IX_EN] == pol_r); // [RULE9]
   // Pin term drops out in command-only mode, command term in pin-only mode
   assign run_req = !cfg_power_up || ((!cfg_cmd_resp || op_r[ON_BIT])
      && (!cfg_pin_resp || pin_act)); // [RULE10] [RULE11] [RULE21] [RULE14]
   assign off_fast = (cfg_pin_resp && !pin_act) ? cfg_pin_action
      : !op_r[SOFT_BIT]; // [RULE16] [RULE22]
   assign mrg_ign = (op_r[MRG_MSB:MRG_LSB] == MRG_NOM_IGN) || (op_r[MRG_MSB:MRG_LSB] == MRG_LOW_IGN)
      || (op_r[MRG_MSB:MRG_LSB] == MRG_HI_IGN); // [RULE20]
   assign uv_eff = mrg_ign ? CFEC_RSP_IGN : uv_resp;
   assign ot_kill = pin_q[IX_OT] && kills(ot_resp);
   // UV checks sleep during the ramp; the timeout only exists there
   assign uvf_evt = pin_q[IX_UVF] && active && !in_ramp; // [RULE4]
   assign ton_evt = pin_q[IX_TON] && in_ramp; // [RULE5]
   assign stat_set[ST_OVW] = pin_q[IX_OVW] && active; // [RULE3]
   assign stat_set[ST_UVW] = pin_q[IX_UVW] && active && !in_ramp; // [RULE3]
   assign stat_set[ST_UVF] = uvf_evt;
   assign stat_set[ST_TON] = ton_evt;
   assign stat_set[ST_OT] = pin_q[IX_OT] || pin_q[IX_BG];
   assign stat_set[ST_VIN] = !pin_q[IX_VIN] && run_req;

   // ==========================================================
   // Sequencer and PWM
   logic [23:0] tmr_r, tmr_nxt;
   logic [7:0] ssc_r, ssc_nxt, pcnt_r, pcnt_nxt;
   logic cool_ot_r, cool_ot_nxt, hs_nxt, ls_nxt, pg_nxt;
   logic [1:0] msel_nxt;
   logic [8:0] ls_len;

   assign ls_len = 9'(pcnt_r - pwm_duty);

   always_comb begin
      st_nxt = st_r;
      tmr_nxt = tmr_r + 24'h000001;
      cool_ot_nxt = cool_ot_r;
      unique case (st_r)
         CFEC_OFF: begin
            tmr_nxt = 24'h000000;
            if (run_req && pin_q[IX_VIN] && !pin_q[IX_BG] && !ot_kill) begin
               st_nxt = CFEC_RAMP; // [RULE15]
            end
         end
         CFEC_LATCH: begin
            if (!run_req) st_nxt = CFEC_OFF; // [RULE19]
         end
         CFEC_HOLD: begin
            if (tmr_r == 24'(RESTART_CYC - 1)) st_nxt = CFEC_OFF; // [RULE4] [RULE5]
         end
         CFEC_COOL: begin
            if (!pin_q[IX_BG] && (!cool_ot_r || pin_q[IX_OTCOOL])) begin
               st_nxt = CFEC_OFF; // [RULE1] [RULE2]
            end
         end
         CFEC_RAMP, CFEC_RUN, CFEC_SOFTOFF: begin
            if (pin_q[IX_BG] || ot_kill) begin
               // Bandgap trip cannot be ignored nor latched
               cool_ot_nxt = !pin_q[IX_BG];
               st_nxt = (pin_q[IX_BG] || restarts(ot_resp)) ? CFEC_COOL
                  : CFEC_LATCH; // [RULE1] [RULE2]
            end else if (!pin_q[IX_VIN]) begin
               st_nxt = CFEC_OFF; // [RULE15]
            end else if ((ton_evt && kills(ton_resp)) || (uvf_evt && kills(uv_eff))) begin
               tmr_nxt = 24'h000000;
               st_nxt = ((ton_evt && restarts(ton_resp)) || (uvf_evt && restarts(uv_eff)))
                  ? CFEC_HOLD : CFEC_LATCH; // [RULE4] [RULE5]
            end else if (!run_req) begin
               if (off_fast) begin
                  st_nxt = CFEC_OFF; // [RULE14] [RULE16] [RULE22]
               end else if (st_r != CFEC_SOFTOFF) begin
                  st_nxt = CFEC_SOFTOFF;
                  tmr_nxt = 24'h000000;
               end else if (tmr_r == 24'(TOFF_CYC - 1)) begin
                  st_nxt = CFEC_OFF; // [RULE16]
               end
            end else if (st_r != CFEC_RAMP) begin
               st_nxt = CFEC_RUN;
            end else if (tmr_r == 24'(RAMP_CYC - 1)) begin
               st_nxt = CFEC_RUN;
            end
         end
         default: st_nxt = CFEC_OFF;
      endcase
      // Free-running period while active: no skipped pulses at light load
      pcnt_nxt = 8'h00;
      ssc_nxt = 8'h00;
      if (active) begin
         pcnt_nxt = (pcnt_r == SW_PERIOD_CYC - 8'h01) ? 8'h00 : pcnt_r + 8'h01; // [RULE6]
         ssc_nxt = (pcnt_r == SW_PERIOD_CYC - 8'h01 && ssc_r != SS_CYCLES)
            ? ssc_r + 8'h01 : ssc_r;
      end
      hs_nxt = active && (pcnt_r < pwm_duty); // [RULE6] [RULE14]
      // Low-side window widens by two clocks per switching cycle
      ls_nxt = active && (pcnt_r >= pwm_duty) && ((ssc_r == SS_CYCLES)
         || (ls_len < {ssc_r, 1'b0})); // [RULE7] [RULE8]
      pg_nxt = (st_r == CFEC_RUN) && !pin_q[IX_OVW] && !pin_q[IX_UVW] && !pin_q[IX_UVF]
         && !pin_q[IX_OT] && !pin_q[IX_BG] && pin_q[IX_VIN]
         && !pin_q[IX_TON]; // [RULE3] [RULE4] [RULE5]
      unique case (op_r[MRG_MSB:MRG_LSB])
         MRG_LOW_IGN, MRG_LOW_ACT: msel_nxt = MSEL_LOW;
         MRG_HI_IGN, MRG_HI_ACT: msel_nxt = MSEL_HIGH;
         default: msel_nxt = MSEL_NOM;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= CFEC_OFF;
         tmr_r <= 24'h000000;
         cool_ot_r <= 1'b0;
         pcnt_r <= 8'h00;
         ssc_r <= 8'h00;
         hs_gate <= 1'b0;
         ls_gate <= 1'b0;
         power_good <= 1'b0;
         margin_sel <= MSEL_NOM;
      end else begin
         st_r <= st_nxt;
         tmr_r <= tmr_nxt;
         cool_ot_r <= cool_ot_nxt;
         pcnt_r <= pcnt_nxt;
         ssc_r <= ssc_nxt;
         hs_gate <= hs_nxt;
         ls_gate <= ls_nxt;
         power_good <= pg_nxt;
         margin_sel <= msel_nxt;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_onbit_gates_off: assert property (cfg_power_up && cfg_cmd_resp && !cfg_pin_resp
      && op_r[7:6] == 2'b00 |-> ##2 !hs_gate && !ls_gate) // [RULE14]
      else $error("gates active with on bit clear");
   a_ls_ramp_start: assert property (active && ssc_r == 8'h00 |=> !ls_gate) // [RULE7]
      else $error("low side on in first switching cycle");
   a_ls_compl: assert property (st_r == CFEC_RUN && ssc_r == SS_CYCLES
      && pcnt_r >= pwm_duty |=> ls_gate && !hs_gate) // [RULE8]
      else $error("low side not complementary");
   a_retry_wait: assert property (st_r == CFEC_HOLD && tmr_r < 24'(RESTART_CYC - 1)
      |=> st_r == CFEC_HOLD) // [RULE4]
      else $error("retry left early");
   a_retry_end: assert property (st_r == CFEC_HOLD && tmr_r == 24'(RESTART_CYC - 1)
      |=> st_r == CFEC_OFF) // [RULE5]
      else $error("retry did not end");
   a_ot_hold: assert property (st_r == CFEC_COOL && cool_ot_r && !pin_q[IX_OTCOOL]
      |=> st_r == CFEC_COOL) // [RULE1]
      else $error("restart before cooling");
   a_bg_forced: assert property (active && pin_q[IX_BG] |=> st_r == CFEC_COOL) // [RULE2]
      else $error("bandgap trip not obeyed");
   a_ovw_pg: assert property (pin_q[IX_OVW] |=> !power_good) // [RULE3]
      else $error("power good high under warning");
   a_both_bits: assert property (req_evt && lk_code_r == OPER_ADDR && lk_wr_r && !slave_r
      && lk_wdata_r[7:6] == 2'b11 |=> ivd_flag && cml_flag && alert && $stable(op_r)) // [RULE18]
      else $error("invalid write not flagged");
   a_slave_nack: assert property (req_evt && lk_code_r == OPER_ADDR && slave_r
      |=> ans_nack_r && ivc_flag && alert && $stable(op_r)) // [RULE13]
      else $error("slave access not refused");
   a_ro_bits: assert property (op_r[1:0] == 2'b00) // [RULE17]
      else $error("read-only bits changed");
   a_pin_only: assert property (st_r == CFEC_RUN && cfg_power_up && cfg_pin_resp
      && !pin_act && cfg_pin_action |=> st_r != CFEC_RUN) // [RULE22]
      else $error("pin off not immediate");

   c_ramp_run: cover property (st_r == CFEC_RAMP ##1 st_r == CFEC_RUN);
   c_retry: cover property (st_r == CFEC_HOLD ##1 st_r == CFEC_OFF);
   c_soft_off: cover property (st_r == CFEC_SOFTOFF ##1 st_r == CFEC_OFF);
endmodule : cfec_ctrl
`default_nettype wire

// File: test/cfec_host.sv
// Link-side host model issuing one command at a time
`timescale 1ns/10ps
`default_nettype none
module cfec_host (
   input wire logic link_clk,
   output logic lk_req,
   output logic lk_write,
   output logic [7:0] lk_code,
   output logic [7:0] lk_wdata,
   input wire logic lk_busy,
   input wire logic lk_done,
   input wire logic lk_nack,
   input wire logic [7:0] lk_rdata
);
   initial begin
      lk_req = 1'b0;
      lk_write = 1'b0;
      lk_code = 8'h00;
      lk_wdata = 8'h00;
   end
   // Released code and data are inverted so the block cannot lean on stale values
   task automatic xfer(input logic wr, input logic [7:0] c, input logic [7:0] d,
                       output logic [7:0] rd, output logic nk, output logic ok);
      int n;
      @(posedge link_clk);
      #1;
      lk_req = 1'b1;
      lk_write = wr;
      lk_code = c;
      lk_wdata = d;
      @(posedge link_clk);
      #1;
      lk_req = 1'b0;
      lk_code = ~c;
      lk_wdata = ~d;
      n = 0;
      while (lk_done !== 1'b1 && n < 40) begin
         @(posedge link_clk);
         #1;
         n++;
      end
      ok = (lk_done === 1'b1);
      rd = lk_rdata;
      nk = lk_nack;
   endtask : xfer
endmodule : cfec_host
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the fault and enable control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import cfec_pkg::*;
   logic clk = 0, link_clk = 0, rst = 1, en_pin = 0, loop_slave = 0;
   logic ov_warn_in = 0, uv_warn_in = 0, uv_fault_in = 0, ton_max_in = 0;
   logic ot_fault_in = 0, ot_cool_in = 0, bg_ot_in = 0, vin_ok_in = 1;
   logic cfg_power_up = 1, cfg_cmd_resp = 1, cfg_pin_resp = 0, cfg_pin_pol = 1;
   logic cfg_pin_action = 1;
   logic [1:0] uv_resp = 2'h1, ton_resp = 2'h1, ot_resp = 2'h1, margin_sel;
   logic [5:0] alert_mask = 6'h00, flt_status;
   logic [7:0] pwm_duty = 8'h40, lk_code, lk_wdata, lk_rdata, rd;
   logic lk_req, lk_write, lk_busy, lk_done, lk_nack, nk, hs_gate, ls_gate;
   logic power_good, alert, cml_flag, ivd_flag, ivc_flag;
   int err_count = 0, total_checks = 0, hs, ls;
   cfec_host cfec_host_inst (.link_clk, .lk_req, .lk_write, .lk_code, .lk_wdata,
      .lk_busy, .lk_done, .lk_nack, .lk_rdata);
   cfec_ctrl #(.RAMP_CYC(20), .RESTART_CYC(140), .TOFF_CYC(600)) cfec_ctrl_inst (.clk, .rst,
      .link_clk, .lk_req, .lk_write, .lk_code, .lk_wdata, .lk_busy, .lk_done, .lk_nack,
      .lk_rdata, .en_pin, .ov_warn_in, .uv_warn_in, .uv_fault_in, .ton_max_in, .ot_fault_in,
      .ot_cool_in, .bg_ot_in, .vin_ok_in, .cfg_power_up, .cfg_cmd_resp, .cfg_pin_resp,
      .cfg_pin_pol, .cfg_pin_action, .loop_slave, .uv_resp, .ton_resp, .ot_resp, .alert_mask,
      .pwm_duty, .hs_gate, .ls_gate, .power_good, .alert, .margin_sel, .flt_status,
      .cml_flag, .ivd_flag, .ivc_flag);
   initial forever #5 clk = ~clk;
   initial forever #32 link_clk = ~link_clk;
   // ==========================================
   // Shared tasks
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic cmd(input logic wr, input logic [7:0] c, input logic [7:0] d);
      logic ok;
      cfec_host_inst.xfer(wr, c, d, rd, nk, ok);
      // Realign to the system clock so later stimulus lands just after its edge
      @(posedge clk);
      #1;
      total_checks++;
      if (ok !== 1'b1 || lk_busy !== 1'b0) begin
         err_count++;
         $display("[FAIL] %0t no answer %h %h", $time, c, d);
         final_report();
      end
   endtask : cmd
   // Gate activity over two switching periods
   task automatic sw_cnt();
      hs = 0;
      ls = 0;
      repeat (400) begin
         @(posedge clk);
         #1;
         if (hs_gate === 1'b1) hs++;
         if (ls_gate === 1'b1) ls++;
      end
   endtask : sw_cnt
   // ==========================================
   // Scenarios
   task automatic t_reset();
      cmd(1'b0, OPER_ADDR, 8'h00);
      chk(rd, OPER_RST);
      chk({hs_gate, ls_gate, power_good, alert}, 8'h00);
   endtask : t_reset
   task automatic t_cmd_only();
      en_pin = 1'b0;
      cmd(1'b1, OPER_ADDR, 8'h83);
      cmd(1'b0, OPER_ADDR, 8'h00);
      chk(rd, 8'h80);
      sw_cnt();
      chk(8'(hs > 0 && ls > 0), 8'h01);
      cmd(1'b1, OPER_ADDR, 8'h40);
      sw_cnt();
      chk(8'(hs > 0), 8'h01);
      repeat (2) sw_cnt();
      chk(8'(hs + ls), 8'h00);
      cmd(1'b1, OPER_ADDR, 8'h80);
      cmd(1'b1, OPER_ADDR, 8'h00);
      chk({hs_gate, ls_gate}, 8'h00);
      sw_cnt();
      chk(8'(hs + ls), 8'h00);
   endtask : t_cmd_only
   task automatic t_invalid();
      cmd(1'b1, OPER_ADDR, 8'hC0);
      chk({nk, ivd_flag, cml_flag, alert}, 8'h07);
      cmd(1'b0, OPER_ADDR, 8'h00);
      chk(rd, 8'h00);
      cmd(1'b1, CLRF_ADDR, 8'h00);
      cmd(1'b1, OPER_ADDR, 8'h90);
      chk({ivd_flag, alert}, 8'h03);
      cmd(1'b1, CLRF_ADDR, 8'h00);
      cmd(1'b0, CLRF_ADDR, 8'h00);
      chk({nk, ivc_flag, cml_flag, ivd_flag}, 8'h0E);
      cmd(1'b1, CLRF_ADDR, 8'h00);
   endtask : t_invalid
   task automatic t_margin();
      logic [7:0] code [5] = '{8'h84, 8'h94, 8'h98, 8'hA4, 8'hA8};
      logic [1:0] sel [5] = '{MSEL_NOM, MSEL_LOW, MSEL_LOW, MSEL_HIGH, MSEL_HIGH};
      for (int i = 0; i < 5; i++) begin
         cmd(1'b1, OPER_ADDR, code[i]);
         repeat (10) @(posedge clk);
         #1;
         chk({ivd_flag, margin_sel}, {6'h00, sel[i]});
      end
   endtask : t_margin
   task automatic t_combined();
      cfg_pin_resp = 1'b1;
      cmd(1'b1, OPER_ADDR, 8'h80);
      sw_cnt();
      chk(8'(hs), 8'h00);
      en_pin = 1'b1;
      sw_cnt();
      chk(8'(hs > 0), 8'h01);
      chk(8'(power_good), 8'h01);
      ov_warn_in = 1'b1;
      sw_cnt();
      chk({hs > 0, power_good, alert, flt_status[ST_OVW]}, 8'h0B);
      ov_warn_in = 1'b0;
      cmd(1'b1, CLRF_ADDR, 8'h00);
   endtask : t_combined
   task automatic t_uv_latch();
      uv_fault_in = 1'b1;
      repeat (20) @(posedge clk);
      #1;
      chk({hs_gate, ls_gate, power_good, flt_status[ST_UVF]}, 8'h01);
      uv_fault_in = 1'b0;
      sw_cnt();
      chk(8'(hs + ls), 8'h00);
   endtask : t_uv_latch
   // Slave role is only caught after a reset, so this one resets mid-run
   task automatic t_slave();
      loop_slave = 1'b1;
      rst = 1'b1;
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (10) @(posedge clk);
      cmd(1'b0, OPER_ADDR, 8'h00);
      chk({nk, ivc_flag, cml_flag, alert}, 8'h0F);
      cmd(1'b1, OPER_ADDR, 8'h80);
      sw_cnt();
      chk({nk, 7'(hs + ls)}, 8'h80);
   endtask : t_slave
   // Reset spans three link edges so the link side leaves reset too
   initial begin
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (10) @(posedge clk);
      t_reset();
      t_cmd_only();
      t_invalid();
      t_margin();
      t_combined();
      t_uv_latch();
      t_slave();
      final_report();
   end
endmodule : tb_top
`default_nettype wire
